// ===== rtl/synth_ctrl_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef SYNTH_CTRL_MAP_VH
`define SYNTH_CTRL_MAP_VH
`define ADDR_CTRL0 4'h0
`define ADDR_CTRL1 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_FEED 4'hc
`define CTRL0_RST 32'h00000000
`define CTRL1_RST 32'h00001210
`define C0_FRAC_LO 4
`define C0_INT_LO 19
`define C0_TXRX 27
`define C0_MUX_LO 29
`define C1_R_LO 4
`define C1_CLKDIV_LO 7
`define C1_OSC_EN 12
`define C1_BIAS_LO 13
`define C1_HALF 18
`define INT_MIN 8'h17
`define MUX_REG_READY 3'h0
`define MUX_FILTER_CAL 3'h1
`define MUX_LOCK 3'h2
`define MUX_RSSI 3'h3
`define MUX_TXRX 3'h4
`define REG_SETTLE_NS 50000
`define CLK_PERIOD_NS 100
`define REG_SETTLE_CYC (`REG_SETTLE_NS / `CLK_PERIOD_NS)
`define LOCK_COUNT 3'h5
`define LOCK_SET_NS 15
`define LOCK_CLR_NS 25
`endif

// ===== rtl/synth_dividers_status_mux.v
// Synthesizer control: dividers, oscillator control, status mux, lock detect
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "synth_ctrl_map.vh"
module synth_dividers_status_mux #(
  parameter REG_SETTLE_CYCLES = `REG_SETTLE_CYC,
  parameter [2:0] LOCK_CYCLES = `LOCK_COUNT
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Chip enable
  input wire chip_enable,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Internal status sources
  input wire filter_cal_busy,
  input wire signal_level_settled,
  input wire pfd_sample,
  input wire [7:0] phase_error_ns,
  // Oscillator and synthesizer outputs
  output reg osc_enable_bit,
  output reg [1:0] osc_bias_field,
  output reg divided_ref_out,
  output reg pfd_ref_clk,
  output reg [7:0] integer_n,
  output reg [14:0] fractional_n,
  output reg output_half_select,
  output reg tx_rx_mode,
  output reg status_select_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [31:0] ctrl0;
  reg [31:0] ctrl1;
  reg [15:0] settle_cnt;
  reg reg_ready;
  reg [3:0] clk_cnt;
  reg clk_phase;
  reg [2:0] r_cnt;
  reg [2:0] good_cnt;
  reg lock;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] next_ctrl0;
  reg [31:0] next_ctrl1;
  reg status_mux;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  wire [3:0] clk_div = ctrl1[`C1_CLKDIV_LO +: 4];
  wire [2:0] r_div = ctrl1[`C1_R_LO +: 3];
  wire [2:0] mux_sel = ctrl0[`C0_MUX_LO +: 3];
  wire [7:0] int_field = ctrl0[`C0_INT_LO +: 8];
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire active = aresetn && chip_enable;
  wire err_small = phase_error_ns < `LOCK_SET_NS;
  wire err_large = phase_error_ns >= `LOCK_CLR_NS;
  wire [4:0] status_word = {tx_rx_mode, signal_level_settled, lock, !filter_cal_busy, reg_ready};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Only the two control words take writes
  function is_writable;
    input [3:0] addr;
    begin
      is_writable = (addr == `ADDR_CTRL0) || (addr == `ADDR_CTRL1);
    end
  endfunction

  // Last count of a divide-by-n counter
  function at_terminal;
    input [3:0] count;
    input [3:0] div;
    begin
      at_terminal = (count >= div - 4'h1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode

  always @* begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    if (do_write && reg_ready && is_writable(aw_addr)) begin
      if (aw_addr == `ADDR_CTRL0) begin
        next_ctrl0 = merge(ctrl0, w_data, w_strb);
      end else if (aw_addr == `ADDR_CTRL1) begin
        next_ctrl1 = merge(ctrl1, w_data, w_strb);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write slave

  always @(posedge aclk) begin
    if (!active) begin
      ctrl0 <= `CTRL0_RST;
      ctrl1 <= `CTRL1_RST;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Writes before regulator ready or to unmapped words are refused
        if (!reg_ready) begin
          s_axi_bresp <= 2'h2;
        end else if (is_writable(aw_addr)) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode

  always @* begin
    next_rresp = 2'h0;
    if (s_axi_araddr == `ADDR_CTRL0) begin
      next_rdata = ctrl0;
    end else if (s_axi_araddr == `ADDR_CTRL1) begin
      next_rdata = ctrl1;
    end else if (s_axi_araddr == `ADDR_STATUS) begin
      next_rdata = {27'h0000000, status_word};
    end else if (s_axi_araddr == `ADDR_FEED) begin
      next_rdata = {8'h00, integer_n, 1'b0, fractional_n};
    end else begin
      // Unmapped words read as zero with an error
      next_rdata = 32'h00000000;
      next_rresp = 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read slave

  always @(posedge aclk) begin
    if (!active) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      // Address is only looked at in the cycle arready is high
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= next_rresp;
        s_axi_rdata <= next_rdata;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator settle timer

  always @(posedge aclk) begin
    if (!active) begin
      settle_cnt <= 16'h0000;
      reg_ready <= 1'b0;
    end else if (settle_cnt == REG_SETTLE_CYCLES[15:0] - 16'h0001) begin
      reg_ready <= 1'b1;
    end else begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator control and feedback divider settings

  always @(posedge aclk) begin
    if (!active) begin
      osc_enable_bit <= 1'b1;
      osc_bias_field <= 2'h0;
      integer_n <= `INT_MIN;
      fractional_n <= 15'h0000;
      output_half_select <= 1'b0;
      tx_rx_mode <= 1'b0;
    end else begin
      osc_enable_bit <= ctrl1[`C1_OSC_EN];
      osc_bias_field <= ctrl1[`C1_BIAS_LO +: 2];
      // Integer below the pulse-swallow minimum is clamped
      integer_n <= (int_field < `INT_MIN) ? `INT_MIN : int_field;
      fractional_n <= ctrl0[`C0_FRAC_LO +: 15];
      output_half_select <= ctrl1[`C1_HALF];
      tx_rx_mode <= ctrl0[`C0_TXRX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output clock divider

  always @(posedge aclk) begin
    if (!active) begin
      clk_cnt <= 4'h0;
      clk_phase <= 1'b0;
      divided_ref_out <= 1'b1;
    end else if (clk_div == 4'h0 || !osc_enable_bit) begin
      clk_cnt <= 4'h0;
      clk_phase <= 1'b0;
      divided_ref_out <= 1'b0;
    end else begin
      // Half period equals the field value, full divide is twice it
      if (at_terminal(clk_cnt, clk_div)) begin
        clk_cnt <= 4'h0;
        clk_phase <= !clk_phase;
      end else begin
        clk_cnt <= clk_cnt + 4'h1;
      end
      divided_ref_out <= !clk_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference counter for the comparison clock

  always @(posedge aclk) begin
    if (!active) begin
      r_cnt <= 3'h0;
      pfd_ref_clk <= 1'b0;
    end else if (r_div <= 3'h1) begin
      r_cnt <= 3'h0;
      pfd_ref_clk <= 1'b1;
    end else if (at_terminal({1'b0, r_cnt}, {1'b0, r_div})) begin
      r_cnt <= 3'h0;
      pfd_ref_clk <= 1'b1;
    end else begin
      r_cnt <= r_cnt + 3'h1;
      pfd_ref_clk <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital lock detect

  always @(posedge aclk) begin
    if (!active) begin
      good_cnt <= 3'h0;
      lock <= 1'b0;
    end else if (pfd_sample) begin
      if (err_large) begin
        good_cnt <= 3'h0;
        lock <= 1'b0;
      end else if (err_small) begin
        if (good_cnt >= LOCK_CYCLES - 3'h1) begin
          lock <= 1'b1;
        end else begin
          good_cnt <= good_cnt + 3'h1;
        end
      end else if (!lock) begin
        good_cnt <= 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status multiplexer

  always @* begin
    case (mux_sel)
      `MUX_REG_READY: status_mux = reg_ready;
      `MUX_FILTER_CAL: status_mux = !filter_cal_busy;
      `MUX_LOCK: status_mux = lock;
      `MUX_RSSI: status_mux = signal_level_settled;
      `MUX_TXRX: status_mux = !tx_rx_mode;
      default: status_mux = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_select_pin <= 1'b0;
    end else begin
      status_select_pin <= chip_enable ? status_mux : 1'b0;
    end
  end

endmodule

// ===== dv/synth_chk.sv
// Port checker for the synthesizer control block
`timescale 1ns/1ps
`include "synth_ctrl_map.vh"
module synth_chk (
  // Clock and resets
  input logic aclk,
  input logic aresetn,
  input logic chip_enable,
  // Register bus handshakes
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Synthesizer outputs
  input logic osc_enable_bit,
  input logic divided_ref_out,
  input logic pfd_ref_clk,
  input logic [7:0] integer_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !chip_enable);
  sequence both_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence osc_off;
    !osc_enable_bit [*3];
  endsequence
  chk_ce_clears:
    assert property (disable iff (!aresetn) !chip_enable |=>
      osc_enable_bit && integer_n == `INT_MIN) else $error("settings kept");
  chk_int_floor:
    assert property (integer_n >= `INT_MIN) else $error("integer below floor");
  chk_osc_stops:
    assert property (osc_off |-> !divided_ref_out) else $error("clock without oscillator");
  chk_pfd_default:
    assert property ($rose(chip_enable) |=> ##1 pfd_ref_clk [*4]) else $error("ratio not one");
  chk_aw_pulse:
    assert property (s_axi_awready |=> !s_axi_awready) else $error("address ready held");
  chk_b_follows:
    assert property (both_taken |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  chk_b_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response kept");
  chk_r_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read kept");
endmodule

// ===== dv/pfd_model.sv
// Phase detector sample source with commanded error
`timescale 1ns/1ps
module pfd_model (
  // Clock and command
  input logic aclk,
  input logic [7:0] err,
  // Sample stream
  output logic pfd_sample = 1'h0,
  output logic [7:0] phase_error_ns = 8'h00
);
  logic [1:0] ph = 2'h0;
  // One sample in four cycles, error bus scrambled in between
  always @(posedge aclk) begin
    ph <= ph + 2'h1;
    pfd_sample <= (ph == 2'h3);
    phase_error_ns <= (ph == 2'h3) ? err : ~phase_error_ns;
  end
endmodule

// ===== dv/synth_dividers_status_mux_tb_top.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`include "synth_ctrl_map.vh"
module synth_dividers_status_mux_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, chip_enable = 1'h1, filter_cal_busy = 1'h0;
  logic signal_level_settled = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, osc_bias_field;
  logic [7:0] phase_error_ns, integer_n, err = 8'h3c;
  logic [14:0] fractional_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pfd_sample, osc_enable_bit, divided_ref_out, pfd_ref_clk, output_half_select;
  logic tx_rx_mode, status_select_pin;
  int n_fail = 0, checks = 0, cyc = 0;
  synth_dividers_status_mux #(.REG_SETTLE_CYCLES(8)) DUT (.*);
  pfd_model pm (.aclk(aclk), .err(err), .pfd_sample(pfd_sample), .phase_error_ns(phase_error_ns));
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end
  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, e);
    repeat (2) @(posedge aclk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, 2'h0);
  endtask
  task cnt(input int n, output int h, output int p);
    h = 0;
    p = 0;
    repeat (n) begin
      @(posedge aclk);
      h += (divided_ref_out === 1'h1);
      p += (pfd_ref_clk === 1'h1);
    end
  endtask
  // Skips a period so a divide change never yields a partial half
  task per(input int e);
    int h, l;
    h = 0;
    l = 0;
    repeat (2) begin
      while (divided_ref_out !== 1'h0) @(posedge aclk);
      while (divided_ref_out !== 1'h1) @(posedge aclk);
    end
    while (divided_ref_out === 1'h1) begin
      h++;
      @(posedge aclk);
    end
    while (divided_ref_out === 1'h0) begin
      l++;
      @(posedge aclk);
    end
    chk(h, e);
    chk(l, e);
  endtask
  task t_power_up;
    int h, p;
    wr(4'h4, 32'h0, 2'h2);
    rd(4'h4, `CTRL1_RST);
    rd(4'h0, `CTRL0_RST);
    chk(osc_enable_bit, 1'h1);
    per(4);
    cnt(8, h, p);
    chk(p, 8);
    chk(status_select_pin, 1'h1);
  endtask
  task t_dividers;
    int h, p;
    wr(4'h4, 32'h000470b0, 2'h0);
    chk(osc_bias_field, 2'h3);
    chk(output_half_select, 1'h1);
    per(1);
    cnt(30, h, p);
    chk(p, 10);
    wr(4'h4, 32'h00001780, 2'h0);
    per(15);
    wr(4'h4, 32'h00001070, 2'h0);
    cnt(28, h, p);
    chk(h, 0);
    chk(p, 4);
    wr(4'h4, 32'h00000200, 2'h0);
    cnt(40, h, p);
    chk(h, 0);
    rd(4'h4, 32'h00000200);
    s_axi_wstrb <= 4'h1;
    wr(4'h4, 32'hffffff30, 2'h0);
    rd(4'h4, 32'h00000230);
    s_axi_wstrb <= 4'hf;
    wr(4'h8, 32'h0, 2'h2);
  endtask
  task t_feedback;
    wr(4'h0, 32'h07fffff0, 2'h0);
    chk({integer_n, fractional_n}, 23'h7fffff);
    wr(4'h0, 32'h08b00000, 2'h0);
    chk({integer_n, fractional_n, tx_rx_mode}, 24'h170001);
  endtask
  // Bits of v: transmit, calibration busy, level settled, expected pin
  task mux(input logic [2:0] m, input logic [3:0] v);
    wr(4'h0, {m, 1'h0, v[3], `INT_MIN, 15'h0, 4'h0}, 2'h0);
    filter_cal_busy <= v[2];
    signal_level_settled <= v[1];
    repeat (3) @(posedge aclk);
    chk(status_select_pin, v[0]);
  endtask
  task t_mux;
    mux(3'h0, 4'h1);
    mux(3'h1, 4'h4);
    mux(3'h1, 4'h1);
    mux(3'h3, 4'h3);
    mux(3'h3, 4'h0);
    mux(3'h4, 4'h8);
    mux(3'h4, 4'h1);
    mux(3'h5, 4'h0);
    mux(3'h2, 4'h0);
  endtask
  task t_lock;
    err <= 8'h0e;
    repeat (40) @(posedge aclk);
    chk(status_select_pin, 1'h1);
    err <= 8'h18;
    repeat (40) @(posedge aclk);
    chk(status_select_pin, 1'h1);
    err <= 8'h19;
    repeat (12) @(posedge aclk);
    chk(status_select_pin, 1'h0);
  endtask
  task t_ce;
    chip_enable <= 1'h0;
    @(posedge aclk);
    chip_enable <= 1'h1;
    @(posedge aclk);
    chk({status_select_pin, osc_enable_bit}, 2'h1);
    rd(4'h4, `CTRL1_RST);
    rd(4'h0, `CTRL0_RST);
    repeat (8) @(posedge aclk);
    chk(status_select_pin, 1'h1);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_power_up();
    t_dividers();
    t_feedback();
    t_mux();
    t_lock();
    t_ce();
    results();
  end
endmodule
bind synth_dividers_status_mux synth_chk chk_i (.*);
